// [hw/ieps_regs.sv]
// Interrupt-enable and frame power-save registers with pin control.
// Assumes an I2C target engine presents byte accesses on the reg port.
`timescale 1ns/1ps
`default_nettype none
module ieps_regs
    import ieps_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr_en,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_rd_en,
    output logic [7:0] reg_rdata_ff,
    output logic reg_rd_valid_ff,
    input wire logic otp_load,
    input wire logic [7:0] otp_pc_defaults,
    input wire logic ovp_pending,
    input wire logic charger_pending,
    input wire logic attach_pending,
    input wire logic other_irq_pending,
    input wire logic irq_pin_drive_type,
    input wire logic irq_pin_active_level,
    input wire logic i2c_mode,
    input wire logic pin_function_select,
    input wire logic charger_found,
    output logic irq_output_pin_out,
    output logic irq_output_pin_oe,
    output logic host_frame_power_save_enable,
    output logic peripheral_frame_power_save_enable,
    output logic [1:0] frame_idle_fraction_select,
    output logic [2:0] frame_idle_shift,
    output logic response_power_save_enable
);
    logic [7:0] ie_ff;
    logic [7:0] pc_ff;
    logic [7:0] nxt_rdata;
    logic irq_real;
    logic irq_asserted;
    logic pin_asserted;
    logic ie_hit;
    logic pc_hit;

    ieps_pin_if pin_bus ();

    // Merge write data under a mask, fixed bits elsewhere
    function automatic logic [7:0] merge(input logic [7:0] wd, input logic [7:0] m, input logic [7:0] f);
        merge = (wd & m) | (f & ~m);
    endfunction

    assign ie_hit = reg_addr == IEPS_IE_OFFSET;
    assign pc_hit = reg_addr == IEPS_PC_OFFSET;

    // ==========================================================
    // Interrupt-enable register
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            ie_ff <= IEPS_IE_RESET;
        else if (ce && reg_wr_en && ie_hit)
            ie_ff <= merge(reg_wdata, IEPS_IE_WMASK, IEPS_IE_RESET);
    end

    // ==========================================================
    // Power-control register
    // OTP load beats a software write in the same cycle
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            pc_ff <= IEPS_PC_RESET;
        else if (ce && otp_load)
            pc_ff <= merge(otp_pc_defaults, IEPS_PC_WMASK, IEPS_PC_FIXED);
        else if (ce && reg_wr_en && pc_hit)
            pc_ff <= merge(reg_wdata, IEPS_PC_WMASK, IEPS_PC_FIXED);
    end

    assign host_frame_power_save_enable = pc_ff[IEPS_HOST_FPS_BIT];
    assign peripheral_frame_power_save_enable = pc_ff[IEPS_PERI_FPS_BIT];
    assign frame_idle_fraction_select = pc_ff[IEPS_FRAC_LSB +: 2];
    // Idle threshold is frame length shifted right by this amount
    assign frame_idle_shift = IEPS_FRAC_BASE_SHIFT - {1'b0, frame_idle_fraction_select};
    assign response_power_save_enable = pc_ff[IEPS_RESP_PS_BIT];

    // ==========================================================
    // Read path; unmapped addresses read 00h
    always_comb
    begin
        nxt_rdata = 8'h00;
        if (ie_hit)
            nxt_rdata = ie_ff;
        else if (pc_hit)
            nxt_rdata = pc_ff;
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            reg_rdata_ff <= 8'h00;
            reg_rd_valid_ff <= 1'b0;
        end
        else if (ce)
        begin
            reg_rd_valid_ff <= reg_rd_en;
            if (reg_rd_en)
                reg_rdata_ff <= nxt_rdata;
        end
    end

    // ==========================================================
    // Interrupt selection
    assign irq_real = (ovp_pending & ie_ff[IEPS_OVP_EN_BIT])
        | (charger_pending & ie_ff[IEPS_CHG_EN_BIT])
        | (attach_pending & ie_ff[IEPS_ATT_EN_BIT])
        | other_irq_pending;
    assign irq_asserted = ie_ff[IEPS_OVR_EN_BIT] ? ie_ff[IEPS_OVR_VAL_BIT] : irq_real;
    // Strap mode has no select bit, so the pin stays the interrupt
    assign pin_asserted = (i2c_mode && pin_function_select) ? charger_found : irq_asserted;

    assign pin_bus.asserted = pin_asserted;
    assign pin_bus.push_pull = irq_pin_drive_type;
    assign pin_bus.active_low = irq_pin_active_level;

    ieps_pin_drive u_pin (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .ce(ce),
        .pin(pin_bus.drv),
        .pin_out_ff(irq_output_pin_out),
        .pin_oe_ff(irq_output_pin_oe)
    );

    // ==========================================================
    // Checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    property p_ie_write;
        ce && reg_wr_en && ie_hit |=> ie_ff == ($past(reg_wdata) & 8'hea);
    endproperty
    a_ie_write: assert property (p_ie_write) else $error("enable write wrong");

    property p_ie_reserved;
        ie_ff[4] == 1'b0 && ie_ff[2] == 1'b0 && ie_ff[0] == 1'b0;
    endproperty
    a_ie_reserved: assert property (p_ie_reserved) else $error("enable reserved bit set");

    property p_pc_write;
        ce && reg_wr_en && pc_hit && !otp_load |=> pc_ff == (($past(reg_wdata) & 8'hce) | 8'h20);
    endproperty
    a_pc_write: assert property (p_pc_write) else $error("power write wrong");

    property p_override;
        ie_ff[7] && !(i2c_mode && pin_function_select) |-> pin_asserted == ie_ff[6];
    endproperty
    a_override: assert property (p_override) else $error("forced level not shown");

    property p_real;
        !ie_ff[7] |-> irq_asserted == ((ovp_pending & ie_ff[1]) | (charger_pending & ie_ff[5])
            | (attach_pending & ie_ff[3]) | other_irq_pending);
    endproperty
    a_real: assert property (p_real) else $error("real interrupt wrong");

    property p_ovp_gate;
        !ie_ff[7] && ovp_pending && !ie_ff[1] && !other_irq_pending && !charger_pending
            && !attach_pending |-> !irq_asserted;
    endproperty
    a_ovp_gate: assert property (p_ovp_gate) else $error("disabled overvoltage shows");

    property p_attach;
        !ie_ff[7] && attach_pending && ie_ff[3] |-> irq_asserted;
    endproperty
    a_attach: assert property (p_attach) else $error("attach not shown");

    property p_select;
        i2c_mode && pin_function_select |-> pin_asserted == charger_found;
    endproperty
    a_select: assert property (p_select) else $error("pin function wrong");

    property p_fraction;
        frame_idle_shift == 3'(5 - pc_ff[3:2]);
    endproperty
    a_fraction: assert property (p_fraction) else $error("idle fraction wrong");

    property p_read;
        ce && reg_rd_en && pc_hit |=> reg_rd_valid_ff && reg_rdata_ff == $past(pc_ff) && reg_rdata_ff[5];
    endproperty
    a_read: assert property (p_read) else $error("power read wrong");

    property p_pin_override;
        ce && ie_ff[7] && ie_ff[6] && !irq_pin_drive_type && !(i2c_mode && pin_function_select)
            |=> irq_output_pin_oe && !irq_output_pin_out;
    endproperty
    a_pin_override: assert property (p_pin_override) else $error("forced pin not low");

    property p_otp_load;
        ce && otp_load |=> pc_ff == (($past(otp_pc_defaults) & 8'hce) | 8'h20);
    endproperty
    a_otp_load: assert property (p_otp_load) else $error("otp defaults not loaded");

    property p_ie_hold;
        !(ce && reg_wr_en && ie_hit) |=> $stable(ie_ff);
    endproperty
    a_ie_hold: assert property (p_ie_hold) else $error("enable changed without write");

    c_override: cover property (ie_ff[7] && ie_ff[6] ##1 irq_output_pin_oe);
    c_otp: cover property (ce && otp_load ##1 pc_ff != IEPS_PC_RESET);
    c_charger: cover property (i2c_mode && pin_function_select && charger_found);
endmodule
`default_nettype wire

// [hw/ieps_pkg.sv]
// Constants for the interrupt-enable and power-save register pair.
// Assumes a byte-wide register port fed by the I2C target engine.
package ieps_pkg;
    localparam logic [7:0] IEPS_IE_OFFSET = 8'hb4;
    localparam logic [7:0] IEPS_PC_OFFSET = 8'hb5;
    localparam logic [7:0] IEPS_IE_RESET = 8'h00;
    localparam logic [7:0] IEPS_PC_RESET = 8'ha2;
    localparam logic [7:0] IEPS_IE_WMASK = 8'hea;
    localparam logic [7:0] IEPS_PC_WMASK = 8'hce;
    localparam logic [7:0] IEPS_PC_FIXED = 8'h20;
    localparam int IEPS_OVR_EN_BIT = 7;
    localparam int IEPS_OVR_VAL_BIT = 6;
    localparam int IEPS_CHG_EN_BIT = 5;
    localparam int IEPS_ATT_EN_BIT = 3;
    localparam int IEPS_OVP_EN_BIT = 1;
    localparam int IEPS_HOST_FPS_BIT = 7;
    localparam int IEPS_PERI_FPS_BIT = 6;
    localparam int IEPS_FRAC_LSB = 2;
    localparam int IEPS_RESP_PS_BIT = 1;
    localparam logic [2:0] IEPS_FRAC_BASE_SHIFT = 3'h5;
endpackage

// [hw/ieps_pin_if.sv]
// Carrier from register logic to the interrupt pin driver.
// Assumes one clock domain shared by both ends.
`timescale 1ns/1ps
`default_nettype none
interface ieps_pin_if;
    logic asserted;
    logic push_pull;
    logic active_low;
    modport src (output asserted, output push_pull, output active_low);
    modport drv (input asserted, input push_pull, input active_low);
endinterface
`default_nettype wire

// [hw/ieps_pin_drive.sv]
// Interrupt pin driver: open-drain (always active low), or push-pull with polarity.
// Assumes the pad resolves level from out and enable.
`timescale 1ns/1ps
`default_nettype none
module ieps_pin_drive
    import ieps_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic ce,
    ieps_pin_if.drv pin,
    output logic pin_out_ff,
    output logic pin_oe_ff
);
    // ==========================================================
    // Pin registers
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pin_out_ff <= 1'b0;
            pin_oe_ff <= 1'b0;
        end
        else if (ce)
        begin
            if (pin.push_pull)
            begin
                pin_out_ff <= pin.asserted ^ pin.active_low;
                pin_oe_ff <= 1'b1;
            end
            else
            begin
                // Open drain only pulls low, never drives high
                pin_out_ff <= 1'b0;
                pin_oe_ff <= pin.asserted;
            end
        end
    end

    // ==========================================================
    // Checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    property p_open_drain;
        ce && !pin.push_pull |=> pin_oe_ff == $past(pin.asserted) && !pin_out_ff;
    endproperty
    a_open_drain: assert property (p_open_drain) else $error("open drain level wrong");

    property p_push_pull;
        ce && pin.push_pull |=> pin_oe_ff && pin_out_ff == ($past(pin.asserted) ^ $past(pin.active_low));
    endproperty
    a_push_pull: assert property (p_push_pull) else $error("push pull level wrong");

    c_od_assert: cover property (ce && !pin.push_pull && pin.asserted ##1 pin_oe_ff);
endmodule
`default_nettype wire

// [verif/ieps_host_model.sv]
// Host model: byte writes and reads on the register port.
// Assumes requests change at the falling edge of ref_clk.
`timescale 1ns/1ps
`default_nettype none
module ieps_host_model
(
    input wire logic ref_clk,
    output logic [7:0] reg_addr,
    output logic reg_wr_en,
    output logic [7:0] reg_wdata,
    output logic reg_rd_en,
    input wire logic [7:0] reg_rdata_ff,
    input wire logic reg_rd_valid_ff
);
    // ==========
    // Bus tasks
    initial
    begin
        reg_addr = 8'h00;
        reg_wr_en = 1'b0;
        reg_wdata = 8'h00;
        reg_rd_en = 1'b0;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge ref_clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr_en = 1'b1;
        @(negedge ref_clk);
        reg_wr_en = 1'b0;
        // Stale data would hide a late sample
        reg_wdata = ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
        int n;
        ok = 1'b0;
        d = 8'h00;
        @(negedge ref_clk);
        reg_addr = a;
        reg_rd_en = 1'b1;
        @(negedge ref_clk);
        reg_rd_en = 1'b0;
        for (n = 0; n < 4 && !ok; n++)
        begin
            if (reg_rd_valid_ff === 1'b1)
            begin
                d = reg_rdata_ff;
                ok = 1'b1;
            end
            else
                @(negedge ref_clk);
        end
    endtask
endmodule
`default_nettype wire

// [verif/tb_irq_enable_and_power_save_regs.sv]
// Testbench for the enable and power-save register pair.
// Assumes ieps_regs and the host model; stimulus at falling edge.
`timescale 1ns/1ps
`default_nettype none
module tb_irq_enable_and_power_save_regs;
    import ieps_pkg::*;
    // ==========
    // Signals
    logic ref_clk = 1'b0, rst_n = 1'b0, ce = 1'b1, otp_load = 1'b0;
    logic [7:0] otp_pc_defaults = 8'h00, reg_addr, reg_wdata, reg_rdata_ff, ie_m, pc_m, w;
    logic reg_wr_en, reg_rd_en, reg_rd_valid_ff, irq_output_pin_out, irq_output_pin_oe;
    logic ovp_pending = 1'b0, charger_pending = 1'b0, attach_pending = 1'b0, other_irq_pending = 1'b0;
    logic irq_pin_drive_type = 1'b0, irq_pin_active_level = 1'b0, i2c_mode = 1'b0;
    logic pin_function_select = 1'b0, charger_found = 1'b0, host_frame_power_save_enable;
    logic peripheral_frame_power_save_enable, response_power_save_enable;
    logic [1:0] frame_idle_fraction_select;
    logic [2:0] frame_idle_shift;
    int bad_count = 0, comparisons = 0, i;
    always #2.5 ref_clk = ~ref_clk;
    ieps_regs uut (.ref_clk, .rst_n, .ce, .reg_addr, .reg_wr_en, .reg_wdata, .reg_rd_en,
        .reg_rdata_ff, .reg_rd_valid_ff, .otp_load, .otp_pc_defaults, .ovp_pending,
        .charger_pending, .attach_pending, .other_irq_pending, .irq_pin_drive_type,
        .irq_pin_active_level, .i2c_mode, .pin_function_select, .charger_found,
        .irq_output_pin_out, .irq_output_pin_oe, .host_frame_power_save_enable,
        .peripheral_frame_power_save_enable, .frame_idle_fraction_select, .frame_idle_shift,
        .response_power_save_enable);
    ieps_host_model host (.ref_clk, .reg_addr, .reg_wr_en, .reg_wdata, .reg_rd_en,
        .reg_rdata_ff, .reg_rd_valid_ff);
    // ==========
    // Expectations and checks
    function automatic logic [7:0] exp_reg(input logic [7:0] a, input logic [7:0] d);
        if (a == 8'hb4)
            return d & 8'hea;
        if (a == 8'hb5)
            return (d & 8'hce) | 8'h20;
        return 8'h00;
    endfunction
    function automatic logic [1:0] exp_pin(input logic [7:0] ie);
        logic act;
        act = ie[7] ? ie[6] : (ovp_pending & ie[1]) | (charger_pending & ie[5])
            | (attach_pending & ie[3]) | other_irq_pending;
        if (i2c_mode && pin_function_select)
            act = charger_found;
        if (!irq_pin_drive_type)
            return {1'b0, act};
        return {act ^ irq_pin_active_level, 1'b1};
    endfunction
    task automatic stop_test();
        $display("comparisons=%0d bad_count=%0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        logic ok;
        host.rd(a, d, ok);
        if (ok !== 1'b1)
        begin
            bad_count++;
            stop_test();
        end
        else
            check(d, e);
    endtask
    task automatic wrm(input logic [7:0] a, input logic [7:0] d);
        host.wr(a, d);
        if (a == 8'hb4)
            ie_m = exp_reg(a, d);
        if (a == 8'hb5)
            pc_m = exp_reg(a, d);
    endtask
    task automatic pwrchk();
        check({host_frame_power_save_enable, peripheral_frame_power_save_enable, 2'b10,
            frame_idle_fraction_select, response_power_save_enable, 1'b0}, pc_m);
        check({5'h00, frame_idle_shift}, 8'h05 - pc_m[3:2]);
    endtask
    // ==========
    // Main sequence
    initial
    begin
        void'($urandom(34629));
        ie_m = 8'h00;
        pc_m = 8'ha2;
        repeat (10) @(posedge ref_clk);
        @(negedge ref_clk) rst_n = 1;
        rdchk(8'hb4, 8'h00);
        rdchk(8'hb5, 8'ha2);
        pwrchk();
        wrm(8'hb6, 8'hff);
        rdchk(8'hb6, 8'h00);
        wrm(8'hb4, 8'hff);
        rdchk(8'hb4, 8'hea);
        wrm(8'hb5, 8'h00);
        rdchk(8'hb5, 8'h20);
        for (i = 0; i < 4; i++)
        begin
            wrm(8'hb5, 8'(i << 2) | (8'($urandom) & 8'hf3));
            pwrchk();
        end
        for (i = 0; i < 60; i++)
        begin
            w = 8'($urandom);
            wrm(i[0] ? 8'hb5 : 8'hb4, w);
            rdchk(i[0] ? 8'hb5 : 8'hb4, i[0] ? pc_m : ie_m);
            pwrchk();
            {ovp_pending, charger_pending, attach_pending, other_irq_pending} = 4'($urandom);
            {irq_pin_drive_type, irq_pin_active_level, charger_found} = 3'($urandom);
            i2c_mode = 1'($urandom);
            pin_function_select = 1'($urandom);
            repeat (2) @(negedge ref_clk);
            check({6'h00, irq_output_pin_out, irq_output_pin_oe}, {6'h00, exp_pin(ie_m)});
        end
        @(negedge ref_clk);
        otp_pc_defaults = 8'($urandom);
        otp_load = 1;
        @(negedge ref_clk) otp_load = 0;
        pc_m = exp_reg(8'hb5, otp_pc_defaults);
        rdchk(8'hb5, pc_m);
        ce = 0;
        host.wr(8'hb5, ~pc_m);
        ce = 1;
        rdchk(8'hb5, pc_m);
        // OTP load and a software write in one cycle: OTP must win
        otp_pc_defaults = ~otp_pc_defaults;
        fork
            host.wr(8'hb5, ~otp_pc_defaults);
            begin
                @(negedge ref_clk) otp_load = 1'b1;
                @(negedge ref_clk) otp_load = 1'b0;
            end
        join
        pc_m = exp_reg(8'hb5, otp_pc_defaults);
        rdchk(8'hb5, pc_m);
        rst_n = 0;
        repeat (2) @(negedge ref_clk);
        check({6'h00, irq_output_pin_out, irq_output_pin_oe}, 8'h00);
        rst_n = 1;
        ie_m = 8'h00;
        pc_m = 8'ha2;
        rdchk(8'hb4, 8'h00);
        pwrchk();
        stop_test();
    end
endmodule
`default_nettype wire
